/* srw_pkg.sv */
// Purpose : Shared constants for the supply reset watchdog
// Assumes : 100 MHz core clock
// Notes   : Times are kept in their own units; cycle counts derive from them

package srw_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned NS_PER_MS       = 1000000;
    localparam int unsigned RST_HOLD_MS     = 200;
    localparam int unsigned WDOG_TIMEOUT_MS = 1600;
    localparam int unsigned RST_HOLD_CYC    = RST_HOLD_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned WDOG_CYC        = WDOG_TIMEOUT_MS * (NS_PER_MS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_N_RESET_VAL   = 1'b0;
    localparam logic ALARM_N_RESET_VAL = 1'b0;
    localparam logic PF_N_RESET_VAL    = 1'b1;

    // ------------------------------------------------------------
    // Reset generator states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        RST_ASSERTED,
        RST_RELEASED
    } rst_state_e;

endpackage

/* wdog_if.sv */
// Purpose : Carrier between the reset generator and the watchdog
// Assumes : Single clock domain
// Notes   : Reset generator drives the hold state, watchdog reports timeout

`timescale 1ns/1ps

interface wdog_if;
    logic reset_active;
    logic timed_out;

    modport ctrl (output reset_active, input timed_out);
    modport wdog (input reset_active, output timed_out);
endinterface

/* srw_watchdog.sv */
// Purpose : Kick-line activity timer
// Assumes : Kick level and float flag synchronous to the clock
// Notes   : Timeout is sticky until the count is cleared

`timescale 1ns/1ps

module srw_watchdog
    import srw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = WDOG_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic kick_i,
    input  wire logic kick_float_i,
    wdog_if.wdog      wd
);

    localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

    // One cycle to see a kick edge and one to flag the timeout
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("srw_watchdog: TIMEOUT_CYC must be at least 2");
    end

    logic [CW-1:0] cnt_q, cnt_d;
    logic          kick_q, kick_d;
    logic          to_q, to_d;

    always_comb begin
        kick_d = kick_i;
        cnt_d  = cnt_q;
        to_d   = to_q;
        if (wd.reset_active || kick_float_i || (kick_i != kick_q)) begin
            cnt_d = '0;
            to_d  = 1'b0;
        end else if (cnt_q == CW'(TIMEOUT_CYC - 1)) begin
            to_d  = 1'b1;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q  <= '0;
            kick_q <= 1'b0;
            to_q   <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            kick_q <= kick_d;
            to_q   <= to_d;
        end
    end

    assign wd.timed_out = to_q;

endmodule

/* supply_reset_watchdog.sv */
// Purpose : Supervisory reset, watchdog and power-fail logic
// Assumes : Supply comparisons arrive as digital levels, synchronous
// Notes   : Variant chosen at build time by HAS_WATCHDOG

`timescale 1ns/1ps

module supply_reset_watchdog
    import srw_pkg::*;
#(
    parameter bit          HAS_WATCHDOG = 1'b1,
    parameter int unsigned HOLD_CYC     = RST_HOLD_CYC,
    parameter int unsigned TIMEOUT_CYC  = WDOG_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic undervoltage_i,
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_kick_in_i,
    input  wire logic kick_float_i,
    input  wire logic supply_sense_low_i,
    output logic      reset_n_o,
    output logic      reset_o,
    output logic      watchdog_alarm_n_o,
    output logic      power_fail_n_o
);

    // ------------------------------------------------------------
    // Build checks
    // ------------------------------------------------------------
    localparam int unsigned HW = $clog2(HOLD_CYC + 1);

    // A hold of zero cycles would let a one-cycle trigger pass with no
    // reset pulse at all, so the build refuses it.
    if (HOLD_CYC < 1) begin : g_bad_hold
        $error("supply_reset_watchdog: HOLD_CYC must be at least 1");
    end

    // The watchdog needs one cycle to see a kick edge and one to flag
    // the timeout; a shorter period cannot be told apart from a kick.
    if (HAS_WATCHDOG && (TIMEOUT_CYC < 2)) begin : g_bad_timeout
        $error("supply_reset_watchdog: TIMEOUT_CYC must be at least 2");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Either a low supply or a held manual input starts a reset.
    function automatic logic reset_trigger(
        input logic uv,
        input logic mr_n
    );
        return uv || !mr_n;
    endfunction

    // The hold counter has reached its last cycle.
    function automatic logic hold_done(
        input logic [HW-1:0] cnt
    );
        return cnt == HW'(HOLD_CYC - 1);
    endfunction

    // Next hold count; never wraps because hold_done ends the count.
    function automatic logic [HW-1:0] hold_step(
        input logic [HW-1:0] cnt
    );
        return cnt + HW'(1);
    endfunction

    // Alarm level: a low supply or a sticky timeout pulls it low.
    function automatic logic alarm_level(
        input logic uv,
        input logic timed_out
    );
        return !(uv || timed_out);
    endfunction

    // ------------------------------------------------------------
    // Reset generator
    // ------------------------------------------------------------
    // Any low manual-reset sample restarts the hold, so bounce is
    // absorbed by the hold period instead of making short pulses.
    rst_state_e    st_q, st_d;
    logic [HW-1:0] hold_q, hold_d;
    logic          rst_n_q, rst_n_d;
    logic          trigger;

    assign trigger = reset_trigger(undervoltage_i, manual_reset_n_i);

    always_comb begin
        st_d    = st_q;
        hold_d  = hold_q;
        rst_n_d = rst_n_q;
        case (st_q)
            RST_ASSERTED: begin
                rst_n_d = 1'b0;
                if (trigger) begin
                    hold_d = '0;
                end else if (hold_done(hold_q)) begin
                    st_d    = RST_RELEASED;
                    rst_n_d = 1'b1;
                end else begin
                    hold_d = hold_step(hold_q);
                end
            end
            RST_RELEASED: begin
                if (trigger) begin
                    st_d    = RST_ASSERTED;
                    hold_d  = '0;
                    rst_n_d = 1'b0;
                end
            end
            default: begin
                st_d    = RST_ASSERTED;
                hold_d  = '0;
                rst_n_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q    <= RST_ASSERTED;
            hold_q  <= '0;
            rst_n_q <= RST_N_RESET_VAL;
        end else begin
            st_q    <= st_d;
            hold_q  <= hold_d;
            rst_n_q <= rst_n_d;
        end
    end

    assign reset_n_o = rst_n_q;

    // ------------------------------------------------------------
    // Variant-specific outputs
    // ------------------------------------------------------------
    // Only one variant exists per build, so the unused function costs
    // no logic; the fixed levels keep the unused pins inactive.
    logic pf_n_q, pf_n_d;
    logic alarm_n_q, alarm_n_d;

    generate
        if (HAS_WATCHDOG) begin : g_wdog
            wdog_if wdl ();
            assign wdl.reset_active = !rst_n_q;

            srw_watchdog #(
                .TIMEOUT_CYC (TIMEOUT_CYC)
            ) u_wdog (
                .core_clk_i   (core_clk_i),
                .sys_rst_i    (sys_rst_i),
                .kick_i       (watchdog_kick_in_i),
                .kick_float_i (kick_float_i),
                .wd           (wdl)
            );

            // Undervoltage drives the alarm directly so it clears with
            // the supply, not after the reset hold.
            always_comb begin
                alarm_n_d = alarm_level(undervoltage_i, wdl.timed_out);
            end
            assign reset_o = 1'b0;
        end else begin : g_dual
            always_comb begin
                alarm_n_d = 1'b1;
            end
            assign reset_o = !rst_n_q;
        end
    endgenerate

    always_comb begin
        pf_n_d = !supply_sense_low_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            alarm_n_q <= ALARM_N_RESET_VAL;
            pf_n_q    <= PF_N_RESET_VAL;
        end else begin
            alarm_n_q <= alarm_n_d;
            pf_n_q    <= pf_n_d;
        end
    end

    assign watchdog_alarm_n_o = HAS_WATCHDOG ? alarm_n_q : 1'b1;
    assign power_fail_n_o     = pf_n_q;

endmodule

/* srw_monitor.sv */
// Purpose: Port checks for the supply reset watchdog
// Assumes: Inputs sampled on the rising clock edge
// Notes  : Watchdog figures allow a few cycles of latency slack

`timescale 1ns/1ps

module srw_monitor #(
    parameter bit          HAS_WATCHDOG = 1'b1,
    parameter int unsigned HOLD_CYC     = 20,
    parameter int unsigned TIMEOUT_CYC  = 50
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic undervoltage_i,
    input wire logic manual_reset_n_i,
    input wire logic watchdog_kick_in_i,
    input wire logic kick_float_i,
    input wire logic supply_sense_low_i,
    input wire logic reset_n_o,
    input wire logic reset_o,
    input wire logic watchdog_alarm_n_o,
    input wire logic power_fail_n_o
);
    // ----
    // Quiet-time counters, saturating so they never wrap
    // ----
    logic [31:0] hold_d, hold_q, wd_d, wd_q;
    logic        kick_d, kick_q;
    always_comb begin
        hold_d = (undervoltage_i || !manual_reset_n_i) ? '0 : hold_q + 32'(hold_q <= HOLD_CYC);
        wd_d   = (!reset_n_o || kick_float_i || watchdog_kick_in_i != kick_q) ? '0
                 : wd_q + 32'(wd_q <= TIMEOUT_CYC + 8);
        kick_d = watchdog_kick_in_i;
    end
    always_ff @(posedge core_clk_i) begin
        hold_q <= sys_rst_i ? '0 : hold_d;
        wd_q   <= sys_rst_i ? '0 : wd_d;
        kick_q <= kick_d;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    hold_match_a: assert property (reset_n_o == (hold_q >= HOLD_CYC))
        else $error("reset output disagrees with hold time");
    dual_out_a: assert property (reset_o == (!HAS_WATCHDOG && !reset_n_o))
        else $error("active-high reset wrong");
    pf_follow_a: assert property (power_fail_n_o == !$past(supply_sense_low_i))
        else $error("power-fail output wrong");
    uv_alarm_a: assert property (HAS_WATCHDOG && undervoltage_i |=> !watchdog_alarm_n_o)
        else $error("alarm not forced by undervoltage");
    uv_clear_a: assert property (HAS_WATCHDOG && $fell(undervoltage_i) |=> watchdog_alarm_n_o)
        else $error("alarm not released after undervoltage");
    wd_early_a: assert property ($fell(watchdog_alarm_n_o) && !$past(undervoltage_i)
        |-> wd_q + 4 >= TIMEOUT_CYC) else $error("alarm before timeout");
    wd_late_a: assert property (HAS_WATCHDOG && wd_q == TIMEOUT_CYC + 2 && !kick_float_i
        |-> ##[0:4] !watchdog_alarm_n_o) else $error("alarm missing after timeout");
    wd_sticky_a: assert property (!watchdog_alarm_n_o && wd_q > TIMEOUT_CYC && reset_n_o
        && manual_reset_n_i && !kick_float_i && watchdog_kick_in_i == kick_q
        |=> !watchdog_alarm_n_o) else $error("timeout alarm not held");
    float_flag_a: assert property (HAS_WATCHDOG && kick_float_i [*3]
        |=> watchdog_alarm_n_o == !$past(undervoltage_i)) else $error("floating kick alarm wrong");
endmodule

bind supply_reset_watchdog srw_monitor #(.HAS_WATCHDOG(HAS_WATCHDOG), .HOLD_CYC(HOLD_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)) i_srw_monitor (.*);

/* srw_cpu_model.sv */
// Purpose: Processor stand-in that toggles the kick line
// Assumes: Kicks only while out of reset and enabled
// Notes  : Kick period sits well inside the watchdog timeout

`timescale 1ns/1ps

module srw_cpu_model #(
    parameter int unsigned KICK_CYC = 10
) (
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic kick_en_i,
    output logic      kick_o
);
    int unsigned n_q;
    initial kick_o = 1'b0;
    always @(posedge core_clk_i) begin
        n_q <= (n_q >= KICK_CYC) ? 0 : n_q + 1;
        if (reset_n_i && kick_en_i && n_q == 0) kick_o <= !kick_o;
    end
endmodule

/* supply_reset_watchdog_tb.sv */
// Purpose: Self-checking bench for both supervisor variants
// Assumes: Shortened hold and timeout counts
// Notes  : Watchdog-variant (rn[0]) reset releases are noted in a queue and matched by a monitor

`timescale 1ns/1ps

module supply_reset_watchdog_tb;
    localparam int HOLD = 20;
    localparam int TMO  = 50;
    logic core_clk_i, sys_rst_i, uv, mr_n, fl, sense, kick_en, kick, rn_p;
    logic [1:0] rn, ro, al, pf;
    int cyc, n_fail, comparisons;
    int exp_q[$];
    logic [31:0] lfsr = 32'h1fea;
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    for (genvar g = 0; g < 2; g++) begin : g_var
        supply_reset_watchdog #(.HAS_WATCHDOG(g == 0), .HOLD_CYC(HOLD), .TIMEOUT_CYC(TMO))
            i_supply_reset_watchdog (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
            .undervoltage_i(uv), .manual_reset_n_i(mr_n), .watchdog_kick_in_i(kick),
            .kick_float_i(fl), .supply_sense_low_i(sense), .reset_n_o(rn[g]),
            .reset_o(ro[g]), .watchdog_alarm_n_o(al[g]), .power_fail_n_o(pf[g]));
    end
    srw_cpu_model i_srw_cpu_model (.core_clk_i(core_clk_i), .reset_n_i(rn[0]),
        .kick_en_i(kick_en), .kick_o(kick));
    task automatic check(logic [31:0] seen, logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // ----
    // Cycle count, hang limit and result monitor
    // ----
    always @(negedge core_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            n_fail++;
            conclude();
        end
    end
    always @(posedge core_clk_i) begin
        if (rn[0] === 1'b1 && rn_p === 1'b0) begin
            if (exp_q.size() == 0) check(cyc, '1);
            else check(cyc, exp_q.pop_front());
        end
        rn_p <= rn[0];
        if (cyc > 1) check(ro[1], !rn[1]);
        if (cyc > 1) check(ro[0], 1'b0);
        if (cyc > 1) check(al[1], 1'b1);
    end
    // ----
    // Stimulus
    // ----
    initial begin
        {uv, fl, sense, kick_en, rn_p} = '0;
        mr_n = 1'b1;
        sys_rst_i = 1'b1;
        tick(16);
        sys_rst_i <= 1'b0;
        kick_en <= 1'b1;
        exp_q.push_back(cyc + HOLD + 1);
        tick(HOLD + 6);
        repeat (16) begin
            lfsr = step(lfsr);
            sense <= lfsr[0];
            tick(1);
            #1 check(pf[0], !sense);
            check(pf[1], !sense);
            tick(1);
        end
        sense <= 1'b0;
        kick_en <= 1'b1;
        tick(3 * TMO);
        #1 check(al[0], 1'b1);
        tick(1);
        kick_en <= 1'b0;
        tick(TMO + 8);
        #1 check(al[0], 1'b0);
        check(rn[0], 1'b1);
        tick(TMO);
        #1 check(al[0], 1'b0);
        tick(1);
        kick_en <= 1'b1;
        tick(14);
        #1 check(al[0], 1'b1);
        tick(1);
        kick_en <= 1'b0;
        tick(TMO - 20);
        repeat (10) begin
            lfsr = step(lfsr);
            mr_n <= lfsr[0];
            tick(1);
        end
        mr_n <= 1'b0;
        tick(1);
        mr_n <= 1'b1;
        exp_q.push_back(cyc + HOLD + 1);
        tick(HOLD + TMO - 10);
        #1 check(al[0], 1'b1);
        tick(20);
        uv <= 1'b1;
        tick(4);
        #1 check(rn[0], 1'b0);
        check(al[0], 1'b0);
        tick(1);
        uv <= 1'b0;
        exp_q.push_back(cyc + HOLD + 1);
        tick(1);
        #1 check(al[0], 1'b1);
        check(rn[0], 1'b0);
        tick(HOLD + 5);
        sys_rst_i <= 1'b1;
        tick(2);
        sys_rst_i <= 1'b0;
        exp_q.push_back(cyc + HOLD + 1);
        tick(HOLD + 5);
        fl <= 1'b1;
        tick(TMO + 10);
        #1 check(al[0], 1'b1);
        tick(1);
        uv <= 1'b1;
        tick(3);
        #1 check(al[0], 1'b0);
        tick(1);
        uv <= 1'b0;
        exp_q.push_back(cyc + HOLD + 1);
        tick(HOLD + 5);
        check(exp_q.size(), 0);
        conclude();
    end
endmodule
